// [logic/ftp_pkg.sv]
// Package for the fuse trim programming block: register map, field
// layout, keys, field codes and timing counts.
// Assumes a single 125 MHz clock; the top, the checker and the bench import it whole.
package ftp_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  // Least high-level pulse width that blows a fuse, in microseconds
  localparam int FUSE_BLOW_TIME_US = 100;
  // Least time as a count of whole clock cycles
  localparam int FUSE_BLOW_CYCLES = FUSE_BLOW_TIME_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Bit fields
  // ----------------------------------------------------------------
  localparam int FIELD_W = 6;
  localparam int FUSE_W = FIELD_W + 1; // Trim field plus lock fuse
  localparam int LOCK_BIT = 3;
  localparam logic [FIELD_W-1:0] FIELD_MAX = 6'h3f;
  localparam logic [FIELD_W-1:0] TRY_START = 6'h01;
  localparam logic [FIELD_W-1:0] ONEHOT_FIRST = 6'h01;
  // Fixed switch hysteresis in operate point steps, not trimmable
  localparam logic [7:0] SWITCH_HYSTERESIS = 8'h04;

  // ----------------------------------------------------------------
  // Register keys, mode key and check codes
  // ----------------------------------------------------------------
  localparam logic [3:0] KEY_TRIM_UP = 4'h0;
  localparam logic [3:0] KEY_TRIM_DOWN = 4'h1;
  localparam logic [3:0] KEY_LOCK_CHECK = 4'h7;
  localparam logic [3:0] KEY_BLOW_MODE = 4'h9;
  localparam logic [3:0] COUNT_MAX = 4'hf;
  localparam logic [FIELD_W-1:0] CODE_CHECK_LOW = 6'h07;
  localparam logic [FIELD_W-1:0] CODE_CHECK_HIGH = 6'h0f;

  // ----------------------------------------------------------------
  // Sequence stages
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_SELECT = 2'b00,
    ST_TRY = 2'b01,
    ST_BLOW = 2'b10,
    ST_DONE = 2'b11
  } ftp_stage_t;

  // ----------------------------------------------------------------
  // Avalon-MM register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_TRIM = 4'h4;
  localparam logic [3:0] ADDR_CONTROL = 4'h8;
  localparam int CTRL_PULSE_EN_BIT = 0;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0001;
  // Status layout
  localparam int ST_STAGE_LSB = 0;
  localparam int ST_KEY_LSB = 4;
  localparam int ST_COUNT_LSB = 8;
  localparam int ST_CODE_LSB = 16;
  localparam int ST_LOCK_BIT = 24;
  localparam int ST_BOOST_BIT = 25;
  // Trim layout
  localparam int TR_FUSE_LSB = 0;
  localparam int TR_OPERATE_LSB = 8;
  localparam int TR_ONEHOT_LSB = 16;

endpackage : ftp_pkg

// [logic/ftp_pulse_rx.sv]
// Pulse receiver: turns the sampled supply-level detector outputs
// into falling-edge events and measures the high-level pulse width.
// Assumes both level inputs are already synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
module ftp_pulse_rx #(
  parameter int BLOW_CYCLES = ftp_pkg::FUSE_BLOW_CYCLES
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic mid_level_i,
  input wire logic high_level_i,
  output logic mid_fall_o,
  output logic high_fall_o,
  output logic high_long_o
);
  localparam int CW = $clog2(BLOW_CYCLES + 1);
  localparam logic [CW-1:0] WIDTH_TARGET = CW'(BLOW_CYCLES);

  logic mid_q_reg;
  logic high_q_reg;
  logic [CW-1:0] width_reg;
  logic [CW-1:0] width_next;

  // ----------------------------------------------------------------
  // Edges and width
  // ----------------------------------------------------------------
  // Counter saturates so a very long blow pulse still reads as long
  assign width_next = !high_level_i ? '0 :
                      (width_reg == WIDTH_TARGET) ? width_reg :
                      width_reg + CW'(1);
  assign mid_fall_o = mid_q_reg & ~mid_level_i;
  assign high_fall_o = high_q_reg & ~high_level_i;
  assign high_long_o = (width_reg == WIDTH_TARGET);

  // Previous levels and running width
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mid_q_reg <= 1'b0;
      high_q_reg <= 1'b0;
      width_reg <= '0;
    end else begin
      mid_q_reg <= mid_level_i;
      high_q_reg <= high_level_i;
      width_reg <= width_next;
    end
  end
endmodule : ftp_pulse_rx
`default_nettype wire

// [logic/ftp_fuse_bank.sv]
// Fuse bank: the trim field fuses and the lock fuse.
// Assumes the supply reset never reaches it; only the manufacturing
// clear (a virgin die) gives it its unblown value.
`timescale 1ns/1ps
`default_nettype none
module ftp_fuse_bank #(
  parameter int WIDTH = ftp_pkg::FUSE_W
) (
  input wire logic clk_i,
  input wire logic mfg_clear_i,
  input wire logic blow_i,
  input wire logic [WIDTH-1:0] blow_bits_i,
  output logic [WIDTH-1:0] fuse_o
);
  logic [WIDTH-1:0] fuse_reg;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Blowing only ORs bits in; nothing but a virgin clear drops one
  always_ff @(posedge clk_i) begin
    if (mfg_clear_i) begin
      fuse_reg <= '0;
    end else if (blow_i) begin
      fuse_reg <= fuse_reg | blow_bits_i;
    end
  end

  assign fuse_o = fuse_reg;
endmodule : ftp_fuse_bank
`default_nettype wire

// [logic/ftp_trim_prog.sv]
// Fuse trim programming logic of a two-wire switch, seen from inside.
// Assumes supply-level detectors deliver mid- and high-level pulse
// levels synchronous to REF_CLK_I, and SRST_I models supply cycling.
//
// Decided for this implementation: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module ftp_trim_prog #(
  parameter int BLOW_CYCLES = ftp_pkg::FUSE_BLOW_CYCLES
) (
  input wire logic REF_CLK_I,
  input wire logic SRST_I,
  input wire logic MFG_CLEAR_I,
  input wire logic MID_LEVEL_PULSE_I,
  input wire logic HIGH_LEVEL_PULSE_I,
  input wire logic [ftp_pkg::FUSE_W-1:0] FUSE_WEAK_BLOWN_I,
  input wire logic [ftp_pkg::FUSE_W-1:0] FUSE_WEAK_INTACT_I,
  input wire logic [3:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  output logic [ftp_pkg::FIELD_W-1:0] OPERATE_POINT_O,
  output logic [7:0] RELEASE_POINT_O,
  output logic SUPPLY_BOOST_O,
  output logic LOCKED_O
);
  import ftp_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ftp_stage_t stage_reg;
  ftp_stage_t stage_next;
  logic [3:0] key_reg;
  logic [3:0] key_next;
  logic [3:0] count_reg;
  logic [3:0] count_next;
  logic [FIELD_W-1:0] code_reg;
  logic [FIELD_W-1:0] code_next;
  logic [FIELD_W-1:0] onehot_reg;
  logic [FIELD_W-1:0] onehot_next;
  logic boost_reg;
  logic [FIELD_W-1:0] operate_reg;
  logic [7:0] release_reg;
  logic [31:0] control_reg;
  logic [31:0] rdata_reg;
  logic ack_reg;

  logic mid_fall_raw;
  logic high_fall_raw;
  logic high_long;
  logic pulse_en;
  logic mid_fall;
  logic high_fall;
  logic [FUSE_W-1:0] fuse;
  logic [FIELD_W-1:0] trim_fuse;
  logic locked;
  logic key_is_trim;
  logic key_is_lock;
  logic select_ok;
  logic enter_blow;
  logic onehot_valid;
  logic blow_ok;
  logic [FUSE_W-1:0] blow_bits;
  logic [FIELD_W-1:0] try_field;
  logic [FIELD_W-1:0] operate_next;
  logic [7:0] release_next;
  logic check_low;
  logic check_high;
  logic marginal;
  logic [3:0] count_inc;
  logic [FIELD_W-1:0] code_inc;
  logic [FIELD_W-1:0] onehot_shift;
  logic bus_req;
  logic sel_status;
  logic sel_trim;
  logic sel_control;
  logic [31:0] status_word;
  logic [31:0] trim_word;
  logic [31:0] rdata_next;
  logic [31:0] control_next;
  logic [31:0] be_mask;

  // ----------------------------------------------------------------
  // Pulse receiver and fuse bank
  // ----------------------------------------------------------------
  ftp_pulse_rx #(
    .BLOW_CYCLES(BLOW_CYCLES)
  ) u_pulse_rx (
    .clk_i(REF_CLK_I),
    .srst_i(SRST_I),
    .mid_level_i(MID_LEVEL_PULSE_I),
    .high_level_i(HIGH_LEVEL_PULSE_I),
    .mid_fall_o(mid_fall_raw),
    .high_fall_o(high_fall_raw),
    .high_long_o(high_long)
  );

  ftp_fuse_bank #(
    .WIDTH(FUSE_W)
  ) u_fuse_bank (
    .clk_i(REF_CLK_I),
    .mfg_clear_i(MFG_CLEAR_I),
    .blow_i(blow_ok),
    .blow_bits_i(blow_bits),
    .fuse_o(fuse)
  );

  // ----------------------------------------------------------------
  // Pulse decode
  // ----------------------------------------------------------------
  // Software can mute the pulse path, e.g. while the test rig settles
  assign pulse_en = control_reg[CTRL_PULSE_EN_BIT];
  assign mid_fall = mid_fall_raw & pulse_en;
  assign high_fall = high_fall_raw & pulse_en;
  assign trim_fuse = fuse[FIELD_W-1:0];
  assign locked = fuse[FIELD_W];
  assign key_is_trim = (key_reg == KEY_TRIM_UP) ||
                       (key_reg == KEY_TRIM_DOWN);
  assign key_is_lock = (key_reg == KEY_LOCK_CHECK);
  assign count_inc = (count_reg == COUNT_MAX) ? count_reg :
                     count_reg + 4'h1;
  assign code_inc = (code_reg == FIELD_MAX) ? code_reg :
                    code_reg + 6'h01;
  assign onehot_shift = (onehot_reg == '0) ? ONEHOT_FIRST :
                        {onehot_reg[FIELD_W-2:0], 1'b0};
  assign onehot_valid = (onehot_reg != '0);

  // Once locked, only the check key may be selected
  assign select_ok = !locked || (count_reg == KEY_LOCK_CHECK);
  // Mode key: exactly nine mid pulses, then a high pulse
  assign enter_blow = high_fall && (count_reg == KEY_BLOW_MODE) &&
                      !locked && (key_is_trim || key_is_lock);

  // ----------------------------------------------------------------
  // Blow request
  // ----------------------------------------------------------------
  // Lock key can only set its own bit; trim keys set one field bit
  assign blow_bits = key_is_lock ?
                     {onehot_reg[LOCK_BIT], {FIELD_W{1'b0}}} :
                     {1'b0, onehot_reg};
  assign blow_ok = (stage_reg == ST_BLOW) && high_fall && high_long &&
                   onehot_valid && !locked &&
                   (blow_bits != '0);

  // ----------------------------------------------------------------
  // Sequence state machine
  // ----------------------------------------------------------------
  always_comb begin
    stage_next = stage_reg;
    key_next = key_reg;
    count_next = count_reg;
    code_next = code_reg;
    onehot_next = onehot_reg;
    unique case (stage_reg)
      ST_SELECT: begin
        if (mid_fall) begin
          count_next = count_inc;
        end else if (high_fall) begin
          count_next = '0;
          if (select_ok) begin
            key_next = count_reg;
            code_next = TRY_START;
            stage_next = ST_TRY;
          end
        end
      end
      ST_TRY: begin
        if (mid_fall) begin
          count_next = count_inc;
          code_next = code_inc;
        end else if (enter_blow) begin
          count_next = '0;
          onehot_next = '0;
          stage_next = ST_BLOW;
        end else if (high_fall) begin
          count_next = '0;
        end
      end
      ST_BLOW: begin
        if (mid_fall) begin
          onehot_next = onehot_shift;
        end else if (high_fall) begin
          stage_next = ST_DONE;
        end
      end
      ST_DONE: begin
        stage_next = ST_DONE;
      end
    endcase
  end

  // Sequence registers; SRST_I stands for a supply cycle
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      stage_reg <= ST_SELECT;
      key_reg <= '0;
      count_reg <= '0;
      code_reg <= '0;
      onehot_reg <= '0;
    end else begin
      stage_reg <= stage_next;
      key_reg <= key_next;
      count_reg <= count_next;
      code_reg <= code_next;
      onehot_reg <= onehot_next;
    end
  end

  // ----------------------------------------------------------------
  // Operate and release points
  // ----------------------------------------------------------------
  // Try value lives only until the next supply cycle; fuses are ORed
  assign try_field = (stage_reg != ST_TRY || !key_is_trim) ? '0 :
                     (key_reg == KEY_TRIM_DOWN) ? ~code_reg :
                     code_reg;
  assign operate_next = trim_fuse | try_field;
  // Hysteresis is a constant; no field reaches it
  assign release_next = {2'b00, operate_next} - SWITCH_HYSTERESIS;

  // ----------------------------------------------------------------
  // Fuse integrity check
  // ----------------------------------------------------------------
  assign check_low = (stage_reg == ST_TRY) && key_is_lock &&
                     (code_reg == CODE_CHECK_LOW);
  assign check_high = (stage_reg == ST_TRY) && key_is_lock &&
                      (code_reg == CODE_CHECK_HIGH);
  assign marginal = (check_high && |(FUSE_WEAK_BLOWN_I & fuse)) ||
                    (check_low && |(FUSE_WEAK_INTACT_I & ~fuse));

  // Output points and current boost
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      operate_reg <= '0;
      // Keeps the fixed offset even on the reset edge
      release_reg <= 8'h00 - SWITCH_HYSTERESIS;
      boost_reg <= 1'b0;
    end else begin
      operate_reg <= operate_next;
      release_reg <= release_next;
      boost_reg <= marginal;
    end
  end

  assign OPERATE_POINT_O = operate_reg;
  assign RELEASE_POINT_O = release_reg;
  assign SUPPLY_BOOST_O = boost_reg;
  assign LOCKED_O = locked;

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  // One wait cycle per access; read data are registered for timing
  assign bus_req = AVS_READ_I | AVS_WRITE_I;
  assign AVS_WAITREQUEST_O = bus_req & ~ack_reg;
  assign sel_status = (AVS_ADDRESS_I == ADDR_STATUS);
  assign sel_trim = (AVS_ADDRESS_I == ADDR_TRIM);
  assign sel_control = (AVS_ADDRESS_I == ADDR_CONTROL);
  assign be_mask = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
                    {8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};

  assign status_word = {6'h00, boost_reg, locked, 2'b00, code_reg,
                        4'h0, count_reg, key_reg,
                        2'b00, stage_reg};
  assign trim_word = {10'h000, onehot_reg, 2'b00, operate_reg,
                      1'b0, fuse};
  // Unmapped addresses read as zero and ignore writes
  assign rdata_next = sel_status ? status_word :
                      sel_trim ? trim_word :
                      sel_control ? control_reg : 32'h0000_0000;
  assign control_next = (control_reg & ~be_mask) |
                        (AVS_WRITEDATA_I & be_mask);

  // Handshake and read data
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      ack_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
      if (AVS_READ_I && !ack_reg) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // Control register
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      control_reg <= CONTROL_RESET;
    end else if (AVS_WRITE_I && ack_reg && sel_control) begin
      control_reg <= control_next & CONTROL_RESET;
    end
  end

  assign AVS_READDATA_O = rdata_reg;
endmodule : ftp_trim_prog
`default_nettype wire

// [dv/ftp_programmer.sv]
// Programmer model: drives mid- and high-level supply pulses.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps
`default_nettype none
module ftp_programmer #(
  parameter int BLOW_CYCLES = 20,
  parameter int HOLD_CYCLES = 8
) (
  input wire logic clk_i,
  output logic mid_o,
  output logic high_o
);
  // Supply rests at its nominal level between pulses
  initial begin
    mid_o = 1'b0;
    high_o = 1'b0;
  end

  // N mid pulses, then one high pulse when a width is given
  task automatic send(input int n_mid, input int high_len);
    repeat (n_mid) begin
      @(posedge clk_i);
      mid_o <= 1'b1;
      repeat (2) @(posedge clk_i);
      mid_o <= 1'b0;
      @(posedge clk_i);
    end
    if (high_len > 0) begin
      @(posedge clk_i);
      high_o <= 1'b1;
      repeat (high_len) @(posedge clk_i);
      high_o <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask : send

  // One fuse per sequence; a short width shows a refused blow
  task automatic blow(input int key, input int bit_pos, input bit ok);
    send(key, 2);
    send(9, 2);
    send(bit_pos + 1, ok ? BLOW_CYCLES + 2 : BLOW_CYCLES - 4);
    repeat (HOLD_CYCLES) @(posedge clk_i);
  endtask : blow
endmodule : ftp_programmer
`default_nettype wire

// [dv/ftp_trim_prog_asserts.sv]
// Checker for the trim programming top: bus wait, release offset,
// lock permanence, lock blow width and check current. Top ports only.
`timescale 1ns/1ps
`default_nettype none
module ftp_chk
  import ftp_pkg::*;
#(
  parameter int BLOW_CYCLES = ftp_pkg::FUSE_BLOW_CYCLES
) (
  input wire logic REF_CLK_I,
  input wire logic SRST_I,
  input wire logic MFG_CLEAR_I,
  input wire logic MID_LEVEL_PULSE_I,
  input wire logic HIGH_LEVEL_PULSE_I,
  input wire logic [ftp_pkg::FUSE_W-1:0] FUSE_WEAK_BLOWN_I,
  input wire logic [ftp_pkg::FUSE_W-1:0] FUSE_WEAK_INTACT_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic [ftp_pkg::FIELD_W-1:0] OPERATE_POINT_O,
  input wire logic [7:0] RELEASE_POINT_O,
  input wire logic SUPPLY_BOOST_O,
  input wire logic LOCKED_O
);
  // -------------------------------------------------------------
  // Helper: width of the last high pulse, kept until the next one
  // -------------------------------------------------------------
  logic [15:0] hi_len_reg;
  logic [15:0] last_len_reg;
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      hi_len_reg <= 16'h0000;
      last_len_reg <= 16'h0000;
    end else begin
      hi_len_reg <= HIGH_LEVEL_PULSE_I ? hi_len_reg + 16'h0001 : 16'h0000;
      if (!HIGH_LEVEL_PULSE_I && hi_len_reg != 16'h0000) begin
        last_len_reg <= hi_len_reg;
      end
    end
  end

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SRST_I);

  sequence s_req_start;
    $rose(AVS_READ_I || AVS_WRITE_I);
  endsequence
  // Five quiet samples cover the full pulse-to-output pipeline
  sequence s_quiet;
    (!MID_LEVEL_PULSE_I && !HIGH_LEVEL_PULSE_I) [*5];
  endsequence

  property p_wait_one;
    s_req_start |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("bus answer not after one wait cycle");
  property p_wait_idle;
    !(AVS_READ_I || AVS_WRITE_I) |-> !AVS_WAITREQUEST_O;
  endproperty
  a_wait_idle: assert property (p_wait_idle)
    else $error("wait raised with no request");
  property p_rdata_hold;
    !$past(AVS_READ_I) && !$past(SRST_I) |-> $stable(AVS_READDATA_O);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without a read");
  property p_release;
    $stable(OPERATE_POINT_O) [*2] |->
      RELEASE_POINT_O == {2'b00, OPERATE_POINT_O} - SWITCH_HYSTERESIS;
  endproperty
  a_release: assert property (p_release)
    else $error("release point offset wrong");
  property p_quiet_op;
    s_quiet |-> $stable(OPERATE_POINT_O);
  endproperty
  a_quiet_op: assert property (p_quiet_op)
    else $error("operate point moved without a pulse");
  property p_boost_cause;
    SUPPLY_BOOST_O |-> $past(|(FUSE_WEAK_BLOWN_I | FUSE_WEAK_INTACT_I));
  endproperty
  a_boost_cause: assert property (p_boost_cause)
    else $error("boost with no marginal fuse");
  property p_lock_sticky;
    @(posedge REF_CLK_I) disable iff (MFG_CLEAR_I) LOCKED_O |=> LOCKED_O;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky)
    else $error("lock fuse cleared");
  property p_lock_long;
    @(posedge REF_CLK_I) disable iff (MFG_CLEAR_I)
      $rose(LOCKED_O) |-> int'(last_len_reg) >= BLOW_CYCLES;
  endproperty
  a_lock_long: assert property (p_lock_long)
    else $error("lock set by a short pulse");
endmodule : ftp_chk
`default_nettype wire

bind ftp_trim_prog ftp_chk #(.BLOW_CYCLES(BLOW_CYCLES)) u_chk (
  .REF_CLK_I(REF_CLK_I), .SRST_I(SRST_I), .MFG_CLEAR_I(MFG_CLEAR_I),
  .MID_LEVEL_PULSE_I(MID_LEVEL_PULSE_I),
  .HIGH_LEVEL_PULSE_I(HIGH_LEVEL_PULSE_I),
  .FUSE_WEAK_BLOWN_I(FUSE_WEAK_BLOWN_I),
  .FUSE_WEAK_INTACT_I(FUSE_WEAK_INTACT_I),
  .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
  .OPERATE_POINT_O(OPERATE_POINT_O), .RELEASE_POINT_O(RELEASE_POINT_O),
  .SUPPLY_BOOST_O(SUPPLY_BOOST_O), .LOCKED_O(LOCKED_O)
);

// [dv/tb.sv]
// Self-checking bench for the trim programming block with a pulse
// programmer model; fuse state is modelled as an integer.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ftp_pkg::*;
  localparam int BLOW = 20;
  logic clk;
  logic srst;
  logic mfg;
  logic mid;
  logic high;
  logic [FUSE_W-1:0] weak_blown;
  logic [FUSE_W-1:0] weak_intact;
  logic [3:0] avs_addr;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_wdata;
  logic [3:0] avs_be;
  logic [31:0] rdata;
  logic waitreq;
  logic [FIELD_W-1:0] op;
  logic [7:0] rel;
  logic boost;
  logic locked;
  logic [31:0] rd;
  int err_count;
  int checked;
  int fuse_m;
  int i;
  int n;
  int blow_bit[4] = '{2, 0, 1, 4};

  ftp_programmer #(.BLOW_CYCLES(BLOW)) prog (.clk_i(clk), .mid_o(mid),
    .high_o(high));
  ftp_trim_prog #(.BLOW_CYCLES(BLOW)) dut (.REF_CLK_I(clk),
    .SRST_I(srst), .MFG_CLEAR_I(mfg), .MID_LEVEL_PULSE_I(mid),
    .HIGH_LEVEL_PULSE_I(high), .FUSE_WEAK_BLOWN_I(weak_blown),
    .FUSE_WEAK_INTACT_I(weak_intact), .AVS_ADDRESS_I(avs_addr),
    .AVS_READ_I(avs_read), .AVS_WRITE_I(avs_write),
    .AVS_WRITEDATA_I(avs_wdata), .AVS_BYTEENABLE_I(avs_be),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
    .OPERATE_POINT_O(op), .RELEASE_POINT_O(rel),
    .SUPPLY_BOOST_O(boost), .LOCKED_O(locked));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Report, compare and bus tasks
  // ------------------------------------------------------------
  task automatic final_report();
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task automatic fail(input string msg);
    err_count++;
    $display("BAD %0t %s", $time, msg);
  endtask : fail

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) fail($sformatf("reg %h exp %h", got, exp));
  endtask : chk_reg

  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) fail($sformatf("flag %b exp %b", got, exp));
  endtask : chk_bit

  // Operate point and its release point move together
  task automatic chk_op(input int exp);
    logic [5:0] e;
    e = exp[5:0];
    checked++;
    if (op !== e || rel !== {2'b00, e} - SWITCH_HYSTERESIS) begin
      fail($sformatf("operate %h release %h exp %h", op, rel, e));
    end
  endtask : chk_op

  function automatic int exp_try(input int key, input int code);
    int c;
    c = (code > 63) ? 63 : code;
    if (key == 1) c = ~c & 63;
    return (fuse_m & 63) | c;
  endfunction : exp_try

  // Request held until wait is seen low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] wd, output logic [31:0] r);
    int k;
    k = 0;
    @(posedge clk);
    avs_addr <= a;
    avs_wdata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    // Wait and read data are looked at only at rising edges
    do begin
      @(posedge clk);
      k++;
    end while (waitreq !== 1'b0 && k < 20);
    if (waitreq !== 1'b0) begin
      fail("bus timeout");
      final_report();
    end
    r = rdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  // Supply cycling keeps only blown fuses
  task automatic power_cycle();
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : power_cycle

  task automatic settle();
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask : settle

  // Low check at code 7, then high check at code 15
  task automatic fuse_check(input int trials);
    logic e;
    prog.send(KEY_LOCK_CHECK, 2);
    prog.send(6, 0);
    for (int t = 0; t < 2 * trials; t++) begin
      if (t == trials) prog.send(8, 0);
      @(posedge clk);
      weak_blown <= 7'(1 << $urandom_range(6, 0));
      weak_intact <= 7'(1 << $urandom_range(6, 0));
      settle();
      e = (t < trials) ? |(weak_intact & ~fuse_m[6:0])
                       : |(weak_blown & fuse_m[6:0]);
      chk_bit(boost, e);
    end
    @(posedge clk);
    weak_blown <= '0;
    weak_intact <= '0;
  endtask : fuse_check

  initial begin
    repeat (100000) @(posedge clk);
    fail("run timeout");
    final_report();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h0802));
    err_count = 0;
    checked = 0;
    fuse_m = 0;
    srst = 1'b1;
    mfg = 1'b1;
    weak_blown = '0;
    weak_intact = '0;
    avs_addr = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_wdata = 32'h0000_0000;
    avs_be = 4'hf;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    mfg <= 1'b0;
    repeat (2) @(posedge clk);
    bus(1'b0, ADDR_CONTROL, 32'h0, rd);
    chk_reg(rd, CONTROL_RESET);
    bus(1'b1, 4'hc, 32'hffff_ffff, rd);
    bus(1'b0, 4'hc, 32'h0, rd);
    chk_reg(rd, 32'h0);
    // Byte 0 disabled: the pulse enable must survive a zero write
    avs_be <= 4'he;
    bus(1'b1, ADDR_CONTROL, 32'h0, rd);
    avs_be <= 4'hf;
    bus(1'b0, ADDR_CONTROL, 32'h0, rd);
    chk_reg(rd, CONTROL_RESET);
    bus(1'b1, ADDR_CONTROL, 32'h0, rd);
    prog.send(KEY_TRIM_UP, 2);
    bus(1'b0, ADDR_STATUS, 32'h0, rd);
    chk_reg(rd & 32'h0300_0003, 32'h0);
    bus(1'b1, ADDR_CONTROL, 32'h1, rd);
    // Try counting both ways, ends of the code range first
    for (i = 0; i < 6; i++) begin
      n = (i == 0) ? 0 : (i == 1) ? 62 : $urandom_range(70, 0);
      power_cycle();
      chk_op(fuse_m & 63);
      prog.send(i % 2, 2);
      prog.send(n, 0);
      settle();
      chk_op(exp_try(i % 2, n + 1));
    end
    // Blow bits 2 then 0, a short pulse on bit 1, bit 4 by down key
    for (i = 0; i < 4; i++) begin
      power_cycle();
      prog.blow((i == 3) ? 1 : 0, blow_bit[i], i != 2);
      power_cycle();
      if (i != 2) fuse_m = fuse_m | (1 << blow_bit[i]);
      chk_op(fuse_m & 63);
      bus(1'b0, ADDR_TRIM, 32'h0, rd);
      chk_reg(rd & 32'h7f, fuse_m);
    end
    power_cycle();
    fuse_check(8);
    // Lock, then a trim-up blow on bit 1 and a trim-up try must be refused
    power_cycle();
    prog.blow(KEY_LOCK_CHECK, LOCK_BIT, 1'b1);
    @(negedge clk);
    fuse_m = fuse_m | 32'h40;
    chk_bit(locked, 1'b1);
    power_cycle();
    chk_bit(locked, 1'b1);
    prog.blow(KEY_TRIM_UP, 1, 1'b1);
    power_cycle();
    bus(1'b0, ADDR_TRIM, 32'h0, rd);
    chk_reg(rd & 32'h7f, fuse_m);
    prog.send(KEY_TRIM_UP, 2);
    prog.send(5, 0);
    settle();
    chk_op(fuse_m & 63);
    power_cycle();
    fuse_check(8);
    final_report();
  end
endmodule : tb
`default_nettype wire
